// ---- design/mdio_uac_defines.svh ----
// Offsets, field positions, reset values and timing of MDIO user access channel 0
// Operation
// - Writing 1 to start bit 31 queues one bus access, run when sequencer free.
// - Writing 0 to the start bit changes nothing.
// - Start bit can be set only while the state machine is enabled.
// - Hardware clears the start bit once the access has finished.
// - While start reads 1, all writes to the user access register are dropped.
// - Bit 30 chooses direction: 1 writes the PHY register, 0 reads it.
// - Acknowledge bit 29 is set when the PHY acknowledged a read.
// - PHY register index comes from bits 25-21.
// - PHY address comes from bits 20-16.
// - Bits 15-0 give write data and receive read data.
// - Link source select bit 7 is 0; state machine decides link status.
// - Link change interrupt enable bit 6 gates the masked link event bit 2.
// - Link of the PHY addressed by select bits 4-0 is watched.
// - Finished user command sets the command done event; writing 1 clears it.
// - Link change of watched PHY sets link event; enable qualifies masked view.
`ifndef MDIO_UAC_DEFINES_SVH
`define MDIO_UAC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UA_OFF    8'h00
`define SEL_OFF   8'h04
`define CTRL_OFF  8'h08
`define EVT_OFF   8'h0c
`define LINK_OFF  8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UA_GO     31
`define UA_WR     30
`define UA_ACK    29
`define SEL_LSRC  7
`define SEL_IRQEN 6
`define EVT_DONE  0
`define EVT_LINK  1
`define EVT_MASK  2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UA_RST    29'h0000000
`define SEL_RST   6'h00
`define CTRL_RST  1'b0

// ----------------------------------------
// Frame layout and timing
// ----------------------------------------
`define PREAMBLE  32'hffffffff
`define START_SEQ 2'b01
`define OP_WRITE  2'b01
`define OP_READ   2'b10
`define TA_DRIVE  2'b10
`define STAT_REG  5'h01
`define LINK_BIT  2
`define LAST_BIT  6'd63
`define TA_BIT    6'd46
`define ACK_BIT   6'd47
`define DATA_BIT  6'd48
`define PCLK_NS   40
`define MDC_HALF_NS 200
`define MDC_HALF_CYC ((`MDC_HALF_NS + `PCLK_NS - 1) / `PCLK_NS)

`endif

// ---- design/mdio_uac_pkg.sv ----
// Types shared by MDIO user access channel 0
package mdio_uac_pkg;

    typedef struct packed {
        logic        go;
        logic        wr;
        logic        ack;
        logic [4:0]  reg_idx;
        logic [4:0]  phy;
        logic [15:0] data;
    } user_cmd_t;

    typedef struct packed {
        logic       irq_en;
        logic [4:0] phy;
    } mon_sel_t;

    typedef enum logic {
        seq_idle,
        seq_shift
    } seq_state_t;

endpackage : mdio_uac_pkg

// ---- design/mdio_user_access_channel0.sv ----
// MDIO user access channel 0 with PHY link monitor behind an APB slave
`timescale 1ns/1ns
`include "mdio_uac_defines.svh"

module mdio_user_access_channel0 #(
    parameter int MDC_HALF = `MDC_HALF_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mdc,
    output logic             mdio_out,
    output logic             mdio_oe,
    input  wire logic        mdio_in
);

    if (MDC_HALF < 2 || MDC_HALF > 256) begin : g_bad_div
        $error("MDC_HALF must lie in 2..256");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    mdio_uac_pkg::user_cmd_t  ua;
    mdio_uac_pkg::mon_sel_t   sel;
    mdio_uac_pkg::seq_state_t state;
    logic                     enable;
    logic                     done_raw;
    logic                     link_raw;
    logic                     link_up;
    logic [7:0]               div;
    logic [5:0]               bit_idx;
    logic [63:0]              frame;
    logic [15:0]              rd_shift;
    logic                     ack_bit;
    logic                     is_user;
    logic                     is_wr;
    logic                     mdio_m1;
    logic                     mdio_m2;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic       setup;
    logic       wr_en;
    logic       wr_ua;
    logic       wr_sel;
    logic       wr_ctrl;
    logic       wr_evt;
    logic       mapped;
    logic       link_masked;
    logic [31:0] rdata;

    assign setup   = psel & ~penable & pce;
    assign wr_en   = psel & penable & pwrite & pce;
    assign wr_ua   = wr_en && paddr == `UA_OFF;
    assign wr_sel  = wr_en && paddr == `SEL_OFF;
    assign wr_ctrl = wr_en && paddr == `CTRL_OFF;
    assign wr_evt  = wr_en && paddr == `EVT_OFF;
    assign mapped  = paddr inside {`UA_OFF, `SEL_OFF, `CTRL_OFF, `EVT_OFF, `LINK_OFF};

    // Zero wait states; a frozen block holds the bus instead
    assign pready  = pce;
    assign pslverr = psel & penable & ~mapped;

    // ----------------------------------------
    // Sequencer timing
    // ----------------------------------------
    logic tick;
    logic rise;
    logic fall;
    logic frame_done;
    logic start;
    logic next_link;
    logic next_wr;
    logic [4:0] next_phy;
    logic [4:0] next_reg;

    assign tick       = pce && state == mdio_uac_pkg::seq_shift && div == 8'(MDC_HALF - 1);
    assign rise       = tick & ~mdc;
    assign fall       = tick & mdc;
    assign frame_done = fall && bit_idx == `LAST_BIT;
    assign start      = pce && state == mdio_uac_pkg::seq_idle && enable;

    // User command wins the next slot; otherwise the watched PHY is polled
    assign next_wr  = ua.go & ua.wr;
    assign next_phy = ua.go ? ua.phy : sel.phy;
    assign next_reg = ua.go ? ua.reg_idx : `STAT_REG;
    assign next_link = ack_bit & rd_shift[`LINK_BIT];

    // ----------------------------------------
    // Frame engine
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= mdio_uac_pkg::seq_idle;
            div     <= 8'h00;
            mdc     <= 1'b0;
            bit_idx <= 6'h00;
            frame   <= 64'h0;
            mdio_oe <= 1'b0;
            is_user <= 1'b0;
            is_wr   <= 1'b0;
        end else if (pce) begin
            unique case (state)
                mdio_uac_pkg::seq_idle: begin
                    if (enable) begin
                        state   <= mdio_uac_pkg::seq_shift;
                        div     <= 8'h00;
                        mdc     <= 1'b0;
                        bit_idx <= 6'h00;
                        mdio_oe <= 1'b1;
                        is_user <= ua.go;
                        is_wr   <= next_wr;
                        frame   <= {`PREAMBLE, `START_SEQ,
                                    next_wr ? `OP_WRITE : `OP_READ,
                                    next_phy, next_reg, `TA_DRIVE,
                                    next_wr ? ua.data : 16'h0000};
                    end
                end
                mdio_uac_pkg::seq_shift: begin
                    div <= tick ? 8'h00 : 8'(div + 8'h01);
                    if (tick) begin
                        mdc <= ~mdc;
                    end
                    if (frame_done) begin
                        state   <= mdio_uac_pkg::seq_idle;
                        mdio_oe <= 1'b0;
                    end else if (fall) begin
                        bit_idx <= 6'(bit_idx + 6'd1);
                        frame   <= {frame[62:0], 1'b0};
                        // Release the line for the PHY's turnaround on reads
                        if (!is_wr && 6'(bit_idx + 6'd1) == `TA_BIT) begin
                            mdio_oe <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    assign mdio_out = frame[63];

    // ----------------------------------------
    // Line sampling
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdio_m1 <= 1'b1;
            mdio_m2 <= 1'b1;
        end else if (pce) begin
            mdio_m1 <= mdio_in;
            mdio_m2 <= mdio_m1;
        end
    end

    // Sampled at the rising MDC edge, a full half period after the PHY drove it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_bit  <= 1'b0;
            rd_shift <= 16'h0000;
        end else if (rise) begin
            if (bit_idx == `ACK_BIT) begin
                ack_bit <= ~mdio_m2;
            end
            if (bit_idx >= `DATA_BIT) begin
                rd_shift <= {rd_shift[14:0], mdio_m2};
            end
        end
    end

    // ----------------------------------------
    // User access register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ua <= mdio_uac_pkg::user_cmd_t'(`UA_RST);
        end else if (pce) begin
            if (frame_done && is_user) begin
                ua.go <= 1'b0;
                if (!is_wr) begin
                    ua.data <= rd_shift;
                    ua.ack  <= ack_bit;
                end
            end else if (wr_ua && !ua.go) begin
                ua.go      <= pwdata[`UA_GO] & enable;
                ua.wr      <= pwdata[`UA_WR];
                ua.ack     <= pwdata[`UA_ACK];
                ua.reg_idx <= pwdata[25:21];
                ua.phy     <= pwdata[20:16];
                ua.data    <= pwdata[15:0];
            end
        end
    end

    // ----------------------------------------
    // Select and control registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel <= mdio_uac_pkg::mon_sel_t'(`SEL_RST);
        end else if (wr_sel) begin
            sel.irq_en <= pwdata[`SEL_IRQEN];
            sel.phy    <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= `CTRL_RST;
        end else if (wr_ctrl) begin
            enable <= pwdata[0];
        end
    end

    // ----------------------------------------
    // Events and link state
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_raw <= 1'b0;
        end else if (pce) begin
            if (frame_done && is_user) begin
                done_raw <= 1'b1;
            end else if (wr_evt && pwdata[`EVT_DONE]) begin
                done_raw <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_up  <= 1'b0;
            link_raw <= 1'b0;
        end else if (pce) begin
            if (frame_done && !is_user) begin
                link_up <= next_link;
            end
            // A new change wins over a clear in the same cycle
            if (frame_done && !is_user && next_link != link_up) begin
                link_raw <= 1'b1;
            end else if (wr_evt && (pwdata[`EVT_LINK] | pwdata[`EVT_MASK])) begin
                link_raw <= 1'b0;
            end
        end
    end

    assign link_masked = link_raw & sel.irq_en;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        unique case (paddr)
            `UA_OFF:   rdata = {ua.go, ua.wr, ua.ack, 3'b000,
                                ua.reg_idx, ua.phy, ua.data};
            `SEL_OFF:  rdata = {24'h000000, 1'b0, sel.irq_en,
                                1'b0, sel.phy};
            `CTRL_OFF: rdata = {31'h00000000, enable};
            `EVT_OFF:  rdata = {29'h00000000, link_masked, link_raw, done_raw};
            `LINK_OFF: rdata = {31'h00000000, link_up};
            default:   rdata = 32'h00000000;
        endcase
    end

    // Registered in the setup cycle so the access phase sees a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            prdata <= rdata;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ua_write;
        wr_ua;
    endsequence

    sequence s_user_done;
        frame_done && is_user;
    endsequence

    chk_go_gated: assert property (
        $rose(ua.go) |-> $past(enable) && $past(wr_ua))
        else $error("start bit set without enable or write");
    chk_zero_no_go: assert property (
        s_ua_write ##0 (!pwdata[`UA_GO] && !ua.go) |=> !ua.go)
        else $error("writing zero set the start bit");
    chk_go_holds: assert property (
        ua.go && pce && !(frame_done && is_user) |=> ua.go)
        else $error("start bit dropped before completion");
    chk_go_locks: assert property (
        s_ua_write ##0 (ua.go && !frame_done) |=> $stable(ua))
        else $error("pending command altered by a write");
    chk_go_self_clear: assert property (
        s_user_done |=> !ua.go && done_raw)
        else $error("start bit or done event wrong at completion");
    chk_frame_fields: assert property (
        start && ua.go |=> frame[27:23] == $past(ua.phy)
            && frame[22:18] == $past(ua.reg_idx)
            && frame[29:28] == ($past(ua.wr) ? `OP_WRITE : `OP_READ))
        else $error("frame fields differ from command");
    chk_read_data: assert property (
        s_user_done ##0 !is_wr |=> ua.data == $past(rd_shift)
            && ua.ack == $past(ack_bit))
        else $error("read result not loaded");
    chk_monitor_addr: assert property (
        start && !ua.go |=> frame[27:23] == $past(sel.phy)
            && frame[22:18] == `STAT_REG)
        else $error("poll frame addresses wrong PHY");
    chk_link_event: assert property (
        frame_done && !is_user && next_link != link_up
            |=> link_raw && link_up == $past(next_link))
        else $error("link change not recorded");
    chk_masked_view: assert property (
        setup && paddr == `EVT_OFF
            |=> prdata[`EVT_MASK] == $past(link_raw && sel.irq_en))
        else $error("masked link view wrong");
    chk_link_src_zero: assert property (
        setup && paddr == `SEL_OFF |=> !prdata[`SEL_LSRC])
        else $error("link source select not zero");

endmodule : mdio_user_access_channel0

// ---- bench/mdio_phy_model.sv ----
// Behavioural PHY answering clause 22 management frames
`timescale 1ns/1ns

module mdio_phy_model #(
    parameter logic [4:0] PHY_ADDR = 5'h03
) (
    input  wire logic mdc,
    input  wire logic mdio_wire,
    input  wire logic link_up,
    output logic      drv_oe,
    output logic      drv_val
);
    logic [15:0] regs [0:31];
    logic [12:0] hdr;
    logic [15:0] shift;
    logic        hit_rd;
    int          ones;
    int          bitn;

    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = 16'h0000;
        end
        hdr = 13'h0000;
        shift = 16'h0000;
        hit_rd = 1'b0;
        ones = 0;
        bitn = 0;
        drv_oe = 1'b0;
        drv_val = 1'b1;
    end

    // ----------------------------------------
    // Frame decode on mdc rise
    // ----------------------------------------
    always @(posedge mdc) begin
        if (bitn == 0) begin
            if (mdio_wire === 1'b1) begin
                ones++;
            end else if (ones >= 32) begin
                bitn = 32;
            end else begin
                ones = 0;
            end
        end else begin
            bitn++;
            if (bitn <= 45) begin
                hdr = {hdr[11:0], mdio_wire};
            end
            if (bitn == 45) begin
                hit_rd = (hdr[11:10] == 2'h2) && (hdr[9:5] == PHY_ADDR);
                shift = regs[hdr[4:0]];
                if (hdr[4:0] == 5'h01) begin
                    shift[2] = link_up;
                end
            end
            if (!hit_rd && bitn >= 48) begin
                shift = {shift[14:0], mdio_wire};
            end
            if (bitn == 63) begin
                if (hdr[11:10] == 2'h1 && hdr[9:5] == PHY_ADDR) begin
                    regs[hdr[4:0]] = shift;
                end
                bitn = 0;
                ones = 0;
                hit_rd = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Read answer, changed after mdc falls
    // ----------------------------------------
    // Absent or addressed elsewhere: line left to the pull-up
    always @(negedge mdc) begin
        if (hit_rd && bitn >= 46 && bitn <= 62) begin
            drv_oe = 1'b1;
            drv_val = (bitn == 46) ? 1'b0 : shift[15];
            if (bitn > 46) begin
                shift = {shift[14:0], 1'b1};
            end
        end else begin
            drv_oe = 1'b0;
        end
    end
endmodule : mdio_phy_model

// ---- bench/mdio_user_access_channel0_tb.sv ----
// Self-checking testbench for MDIO user access channel 0
`timescale 1ns/1ns
`include "mdio_uac_defines.svh"

module mdio_user_access_channel0_tb;
    logic        pclk;
    logic        presetn;
    logic        pce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mdc;
    logic        mdio_out;
    logic        mdio_oe;
    logic        mdio_in;
    logic        link_up;
    logic        phy_oe;
    logic        phy_val;
    logic [31:0] rd_data;
    logic        rd_err;
    logic [2:0]  frz;
    int          failures;
    int          n_checks;

    // Pull-up on the shared line
    assign mdio_in = mdio_oe ? mdio_out : (phy_oe ? phy_val : 1'b1);

    mdio_user_access_channel0 #(.MDC_HALF(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mdc(mdc), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .mdio_in(mdio_in)
    );

    mdio_phy_model #(.PHY_ADDR(5'h03)) phy_u (
        .mdc(mdc), .mdio_wire(mdio_in), .link_up(link_up),
        .drv_oe(phy_oe), .drv_val(phy_val)
    );

    always #20 pclk = ~pclk;

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_checks++;
        if ((got & m) !== (exp & m)) begin
            failures++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        check(rd_data, exp, m);
    endtask : rd_chk

    // Bounded poll; a hang shows as go still set in the next compare
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            apb(1'b0, `UA_OFF, 32'h0);
            n++;
        end while (rd_data[31] !== 1'b0 && n < 600);
    endtask : wait_done

    function automatic logic [31:0] ua(input logic go, input logic wr, input logic ack,
                                       input logic [4:0] r, input logic [4:0] p,
                                       input logic [15:0] d);
        return {go, wr, ack, 3'h0, r, p, d};
    endfunction : ua

    task finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        pce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        link_up = 1'b0;
        failures = 0;
        n_checks = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`UA_OFF, 32'h0, 32'hffffffff);
        rd_chk(`SEL_OFF, 32'h0, 32'hffffffff);
        apb(1'b0, 8'h14, 32'h0);
        check({31'h0, rd_err}, 32'h1, 32'hffffffff);
        apb(1'b1, `UA_OFF, ua(1'b1, 1'b1, 1'b0, 5'h05, 5'h03, 16'h1111));
        rd_chk(`UA_OFF, 32'h0, 32'h80000000);
        apb(1'b1, `SEL_OFF, 32'hffffffff);
        rd_chk(`SEL_OFF, 32'h5f, 32'hffffffff);
        apb(1'b1, `SEL_OFF, 32'h43);
        apb(1'b1, `CTRL_OFF, 32'h1);
        apb(1'b1, `UA_OFF, ua(1'b1, 1'b1, 1'b0, 5'h05, 5'h03, 16'hbeef));
        apb(1'b1, `UA_OFF, ua(1'b0, 1'b0, 1'b0, 5'h07, 5'h01, 16'h0000));
        rd_chk(`UA_OFF, ua(1'b1, 1'b1, 1'b0, 5'h05, 5'h03, 16'hbeef), 32'hffffffff);
        wait_done;
        check(rd_data, ua(1'b0, 1'b1, 1'b0, 5'h05, 5'h03, 16'hbeef), 32'hffffffff);
        check({16'h0, phy_u.regs[5]}, 32'hbeef, 32'hffffffff);
        rd_chk(`EVT_OFF, 32'h1, 32'h1);
        apb(1'b1, `EVT_OFF, 32'h1);
        rd_chk(`EVT_OFF, 32'h0, 32'h1);
        apb(1'b1, `UA_OFF, ua(1'b0, 1'b1, 1'b0, 5'h05, 5'h03, 16'h1234));
        repeat (1200) @(posedge pclk);
        rd_chk(`EVT_OFF, 32'h0, 32'h1);
        check({16'h0, phy_u.regs[5]}, 32'hbeef, 32'hffffffff);
        apb(1'b1, `UA_OFF, ua(1'b1, 1'b0, 1'b0, 5'h05, 5'h03, 16'h0000));
        wait_done;
        check(rd_data, ua(1'b0, 1'b0, 1'b1, 5'h05, 5'h03, 16'hbeef), 32'hffffffff);
        apb(1'b1, `UA_OFF, ua(1'b1, 1'b0, 1'b1, 5'h05, 5'h09, 16'h0000));
        wait_done;
        check(rd_data, ua(1'b0, 1'b0, 1'b0, 5'h05, 5'h09, 16'hffff), 32'hffffffff);
        // Link monitor: event with and without the enable
        apb(1'b1, `EVT_OFF, 32'h7);
        link_up <= 1'b1;
        repeat (1500) @(posedge pclk);
        rd_chk(`LINK_OFF, 32'h1, 32'h1);
        rd_chk(`EVT_OFF, 32'h6, 32'h6);
        apb(1'b1, `SEL_OFF, 32'h03);
        apb(1'b1, `EVT_OFF, 32'h6);
        link_up <= 1'b0;
        repeat (1500) @(posedge pclk);
        rd_chk(`LINK_OFF, 32'h0, 32'h1);
        rd_chk(`EVT_OFF, 32'h2, 32'h6);
        // Watched address decides: an absent PHY keeps the link down
        apb(1'b1, `SEL_OFF, 32'h09);
        // Let any poll of the old address finish before the link moves
        repeat (600) @(posedge pclk);
        apb(1'b1, `EVT_OFF, 32'h6);
        link_up <= 1'b1;
        repeat (1500) @(posedge pclk);
        rd_chk(`LINK_OFF, 32'h0, 32'h1);
        rd_chk(`EVT_OFF, 32'h0, 32'h2);
        // Clock enable low freezes mdc, mdio_oe and mdio_out and holds pready low
        pce <= 1'b0;
        @(negedge pclk);
        frz = {mdc, mdio_oe, mdio_out};
        repeat (20) @(negedge pclk);
        check({29'h0, mdc, mdio_oe, mdio_out}, {29'h0, frz}, 32'h7);
        check({31'h0, pready}, 32'h0, 32'h1);
        @(posedge pclk);
        pce <= 1'b1;
        finish_test;
    end

    initial begin
        repeat (30000) @(posedge pclk);
        failures++;
        finish_test;
    end
endmodule : mdio_user_access_channel0_tb
